//--- design/trace_evt_pkg.sv
// Constants, field layouts and carriers for the trace event select block.
// Assumes a single core clock and a debugger that issues one access at a time.
// Summary of operation
// - Each event has a kind bit: zero follows one resource, one follows a pair.
// - Kind zero: four choice bits pick single resource 0 to 15.
// - Kind one: low three choice bits pick combined pair 0 to 7.
// - Event 1 choice at bits 11:8, kind bit 15; event 0 at 3:0, kind 7.
// - Enable bits 3:0 let each occurring event emit an event element.
// - Bit 11 of the behaviour register enables the trace bus trigger.
// - Bit 12 set keeps resources and events running in core low power.
// - Four six-bit fields pick external input bus lines as external resources.
// - Capability reports event count minus one, showing four events.
// - Timestamp width field reports a global timestamp of up to 64 bits.
// - Return stack, cycle counting and branch broadcast are reported implemented.
// - Data trace, conditional trace, Q elements, Q filter, P0 loads/stores unsupported.
// - Commit interpretation bit reports commit mode 1.
// - Cycle counter width field is width minus twelve, reporting 12 bits.
// - Sizes report 32-bit VM identifier, 32-bit context identifier, 64-bit address.
// - Two-bit field reports the VM context source option as implemented.
// - Eight-bit code field at 31:24 names the code_a; debugger reads it.
// - Major version at 11:8, minor at 7:4, revision at 3:0.
// - Selected events also drive the external event outputs.
// - Event 3 kind at bit 31, event 2 kind at bit 23, same meaning.
package trace_evt_pkg;

    // Register offsets on the debug port
    localparam logic [11:0] OFF_EVT_SELECT   = 12'h020;
    localparam logic [11:0] OFF_EVT_BEHAV    = 12'h024;
    localparam logic [11:0] OFF_EXT_SELECT   = 12'h120;
    localparam logic [11:0] OFF_CAP0         = 12'h1E0;
    localparam logic [11:0] OFF_BASE_ID      = 12'h1E4;
    localparam logic [11:0] OFF_PARAM_SIZES  = 12'h1E8;
    localparam logic [11:0] OFF_CAP3         = 12'h1EC;

    // Writable bit masks and reset values
    localparam logic [31:0] EVT_SELECT_MASK  = 32'h8F8F_8F8F;
    localparam logic [31:0] EVT_BEHAV_MASK   = 32'h0000_180F;
    localparam logic [31:0] EXT_SELECT_MASK  = 32'h3F3F_3F3F;
    localparam logic [31:0] CTRL_RESET       = 32'h0000_0000;

    // Field positions
    localparam int NUM_EVENTS     = 4;
    localparam int FIELD_STRIDE   = 8;
    localparam int KIND_BIT       = 7;
    localparam int CHOICE_W       = 4;
    localparam int EN_LSB         = 0;
    localparam int BUS_TRIG_BIT   = 11;
    localparam int LP_BYPASS_BIT  = 12;
    localparam int EXT_SEL_W      = 6;
    localparam int EXT_IN_COUNT   = 47;
    localparam int NUM_SINGLE     = 16;
    localparam int NUM_PAIR       = 8;

    // Capability register 0 fields
    localparam logic       COMMIT_INTERPRETATION     = 1'h1;
    localparam logic [4:0] TIMESTAMP_WIDTH           = 5'h08;
    localparam logic [1:0] Q_ELEMENT_SUPPORT         = 2'h0;
    localparam logic       Q_FILTER_SUPPORT          = 1'h0;
    localparam logic [1:0] COND_RESULT_TRACE         = 2'h0;
    localparam logic [1:0] EVENT_COUNT_MINUS_ONE     = 2'h3;
    localparam logic       RETURN_STACK_SUPPORT      = 1'h1;
    localparam logic       CYCLE_COUNT_SUPPORT       = 1'h1;
    localparam logic       CONDITIONAL_TRACE_SUPPORT = 1'h0;
    localparam logic       BRANCH_BROADCAST_SUPPORT  = 1'h1;
    localparam logic [1:0] DATA_TRACE_SUPPORT        = 2'h0;
    localparam logic [1:0] LOAD_STORE_P0_SUPPORT     = 2'h0;
    localparam logic [31:0] CAP0_VALUE = {2'h0, COMMIT_INTERPRETATION, TIMESTAMP_WIDTH,
        7'h00, Q_ELEMENT_SUPPORT, Q_FILTER_SUPPORT, COND_RESULT_TRACE,
        EVENT_COUNT_MINUS_ONE, RETURN_STACK_SUPPORT, 1'h0, CYCLE_COUNT_SUPPORT,
        CONDITIONAL_TRACE_SUPPORT, BRANCH_BROADCAST_SUPPORT, DATA_TRACE_SUPPORT,
        LOAD_STORE_P0_SUPPORT, 1'h1};

    // Parameter size register fields
    localparam logic [1:0] VM_CONTEXT_SOURCE_OPTION  = 2'h1;
    localparam logic [3:0] CYCLE_COUNTER_WIDTH       = 4'h0;
    localparam logic [4:0] VM_IDENTIFIER_WIDTH       = 5'h04;
    localparam logic [4:0] CONTEXT_IDENTIFIER_WIDTH  = 5'h04;
    localparam logic [4:0] INSTRUCTION_ADDRESS_WIDTH = 5'h08;
    localparam logic [31:0] PARAM_SIZES_VALUE = {1'h0, VM_CONTEXT_SOURCE_OPTION,
        CYCLE_COUNTER_WIDTH, 5'h00, 5'h00, VM_IDENTIFIER_WIDTH,
        CONTEXT_IDENTIFIER_WIDTH, INSTRUCTION_ADDRESS_WIDTH};

    // Capability register 3, fixed
    localparam logic [31:0] CAP3_VALUE = {1'h0, 3'h0, 1'h1, 1'h1, 1'h0, 1'h1,
        4'h7, 4'hB, 4'h0, 12'h004};

    // Base identity fixed fields
    localparam logic [7:0] BASE_ID_RES0 = 8'h00;
    localparam logic [3:0] BASE_ID_RES1 = 4'hF;

    // Debug access request and answer
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [11:0] addr;
        logic [31:0] wdata;
    } dbg_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
    } dbg_rsp_t;

    // Resource selector outputs feeding the events
    typedef struct packed {
        logic [15:0] single;
        logic [7:0]  pair;
    } resource_bus_t;

    // Whole state of the register block
    typedef struct packed {
        logic [31:0] evtSelect;
        logic [31:0] evtBehaviour;
        logic [31:0] extSelect;
        dbg_rsp_t    rsp;
        logic [3:0]  eventOut;
        logic [3:0]  eventElement;
        logic [3:0]  extResource;
    } trace_state_t;

endpackage

//--- design/event_resource_pick.sv
// Picks the resource that drives one trace event.
// Assumes resource levels are synchronous to the core clock.
`timescale 1ns/1ps
module event_resource_pick (
    // Event control field
    input  wire logic        kind,
    input  wire logic [3:0]  choice,
    // Resource levels
    input  wire logic [15:0] single,
    input  wire logic [7:0]  pair,
    // Chosen level
    output logic             hit
);
    // Single resource by four bits, pair by low three bits
    always_comb begin
        if (kind) begin
            hit = pair[choice[2:0]];
        end else begin
            hit = single[choice];
        end
    end
endmodule // event_resource_pick

//--- design/trace_event_regs.sv
// Trace event select, external input select and identity registers.
// Assumes one debug access at a time; resources and inputs are synchronous.
`timescale 1ns/1ps
module trace_event_regs #(
    parameter logic [7:0] CODE_A             = 8'h5A, // Arbitrary value
    parameter logic [3:0] ARCH_MAJOR_VERSION = 4'h7,  // Arbitrary value
    parameter logic [3:0] ARCH_MINOR_VERSION = 4'h3,  // Arbitrary value
    parameter logic [3:0] IMPL_REVISION      = 4'h1   // Arbitrary value
) (
    // Clock and reset
    input  wire logic                        core_clk,
    input  wire logic                        rst_n,
    // External debug register port
    input  wire trace_evt_pkg::dbg_req_t     dbgReq,
    output trace_evt_pkg::dbg_rsp_t          dbgRsp,
    // Resource levels from the selectors
    input  wire trace_evt_pkg::resource_bus_t resources,
    // External input bus
    input  wire logic [46:0]                 extInBus,
    // Core power state
    input  wire logic                        coreLowPower,
    // Event outputs
    output logic [3:0]                       eventElement,
    output logic [3:0]                       eventOut,
    // External input resources
    output logic [3:0]                       extResource,
    // Control levels
    output logic                             busTriggerEnable,
    output logic                             lowPowerBypass
);
    import trace_evt_pkg::*;

    trace_state_t stateReg;
    trace_state_t stateNext;
    logic [3:0]   eventHit;
    logic [3:0]   extPick;
    logic [31:0]  readData;
    logic [31:0]  baseIdValue;
    logic         eventsLive;

    // Base identity assembled from the identity parameters
    assign baseIdValue = {CODE_A, BASE_ID_RES0, BASE_ID_RES1,
                          ARCH_MAJOR_VERSION,
                          ARCH_MINOR_VERSION,
                          IMPL_REVISION};

    // One resource picker per event
    for (genvar i = 0; i < NUM_EVENTS; i++) begin : gEvt
        event_resource_pick uPick (
            .kind   (stateReg.evtSelect[i*FIELD_STRIDE+KIND_BIT]),
            .choice (stateReg.evtSelect[i*FIELD_STRIDE +: CHOICE_W]),
            .single (resources.single),
            .pair   (resources.pair),
            .hit    (eventHit[i])
        );
    end

    // External input line chosen per resource
    for (genvar j = 0; j < NUM_EVENTS; j++) begin : gExt
        logic [5:0] extChoice;
        assign extChoice = stateReg.extSelect[j*FIELD_STRIDE +: EXT_SEL_W];
        always_comb begin
            if (extChoice < 6'(EXT_IN_COUNT)) begin
                extPick[j] = extInBus[extChoice];
            end else begin
                extPick[j] = 1'b0;
            end
        end
    end

    // Read data by offset
    always_comb begin
        unique case (dbgReq.addr)
            OFF_EVT_SELECT:  readData = stateReg.evtSelect;
            OFF_EVT_BEHAV:   readData = stateReg.evtBehaviour;
            OFF_EXT_SELECT:  readData = stateReg.extSelect;
            OFF_CAP0:        readData = CAP0_VALUE;
            OFF_BASE_ID:     readData = baseIdValue;
            OFF_PARAM_SIZES: readData = PARAM_SIZES_VALUE;
            OFF_CAP3:        readData = CAP3_VALUE;
            default:         readData = 32'h0000_0000;
        endcase
    end

    // Low power clears events and external resources unless bypass is set
    assign eventsLive = !(coreLowPower
                          && !stateReg.evtBehaviour[LP_BYPASS_BIT]);

    // Next state: register writes, answers and event outputs
    always_comb begin
        stateNext = stateReg;
        stateNext.rsp = '0;
        if (dbgReq.valid) begin
            stateNext.rsp.ack = 1'b1;
            if (dbgReq.write) begin
                unique case (dbgReq.addr)
                    OFF_EVT_SELECT: begin
                        // Reserved bits dropped on write
                        stateNext.evtSelect = dbgReq.wdata & EVT_SELECT_MASK;
                    end
                    OFF_EVT_BEHAV: begin
                        stateNext.evtBehaviour = dbgReq.wdata & EVT_BEHAV_MASK;
                    end
                    OFF_EXT_SELECT: begin
                        stateNext.extSelect = dbgReq.wdata & EXT_SELECT_MASK;
                    end
                    default: begin
                        // Identity and unmapped offsets ignore writes
                        stateNext.rsp.rdata = 32'h0000_0000;
                    end
                endcase
            end else begin
                stateNext.rsp.rdata = readData;
            end
        end
        if (eventsLive) begin
            stateNext.eventOut = eventHit;
            stateNext.extResource = extPick;
        end else begin
            stateNext.eventOut = 4'h0;
            stateNext.extResource = 4'h0;
        end
        stateNext.eventElement = stateNext.eventOut
            & stateReg.evtBehaviour[EN_LSB +: NUM_EVENTS];
    end

    // State register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stateReg <= '{evtSelect:    CTRL_RESET,
                          evtBehaviour: CTRL_RESET,
                          extSelect:    CTRL_RESET,
                          default:      '0};
        end else begin
            stateReg <= stateNext;
        end
    end

    // Outputs straight from flip-flops
    assign dbgRsp = stateReg.rsp;
    assign eventOut = stateReg.eventOut;
    assign eventElement = stateReg.eventElement;
    assign extResource = stateReg.extResource;
    assign busTriggerEnable = stateReg.evtBehaviour[BUS_TRIG_BIT];
    assign lowPowerBypass = stateReg.evtBehaviour[LP_BYPASS_BIT];

    // Helper levels for the checks below
    logic       singleHit0;
    logic       pairHit1;
    logic       extHit0;
    logic [5:0] extChoice0;
    logic       isWrite;
    logic       isRead;
    assign singleHit0 = resources.single[stateReg.evtSelect[3:0]];
    assign pairHit1 = resources.pair[stateReg.evtSelect[10:8]];
    assign extChoice0 = stateReg.extSelect[5:0];
    assign extHit0 = (extChoice0 < 6'(EXT_IN_COUNT)) ? extInBus[extChoice0] : 1'b0;
    assign isWrite = dbgReq.valid && dbgReq.write;
    assign isRead = dbgReq.valid && !dbgReq.write;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    a_single_kind_pick:
    assert property (
        (!stateReg.evtSelect[7] && eventsLive && !isWrite)
        |=> eventOut[0] == $past(singleHit0))
    else $error("Event 0 single resource pick wrong");

    a_pair_kind_pick:
    assert property (
        (stateReg.evtSelect[15] && eventsLive && !isWrite)
        |=> eventOut[1] == $past(pairHit1))
    else $error("Event 1 pair resource pick wrong");

    a_element_enable_gate:
    assert property (
        ##1 eventElement == (eventOut & $past(stateReg.evtBehaviour[3:0])))
    else $error("Event element not gated by enable");

    a_low_power_stall:
    assert property (
        (coreLowPower && !lowPowerBypass)
        |=> (eventOut == 4'h0) && (extResource == 4'h0))
    else $error("Events ran during low power without bypass");

    a_bus_trigger_write:
    assert property (
        (isWrite && dbgReq.addr == OFF_EVT_BEHAV)
        |=> busTriggerEnable == $past(dbgReq.wdata[11]))
    else $error("Bus trigger enable not taken from write");

    a_ext_input_pick:
    assert property (
        (eventsLive && !isWrite) |=> extResource[0] == $past(extHit0))
    else $error("External resource 0 pick wrong");

    a_cap0_read_value:
    assert property (
        (isRead && dbgReq.addr == OFF_CAP0)
        |=> dbgRsp.ack && dbgRsp.rdata == 32'h2800_0EA1)
    else $error("Capability 0 read value wrong");

    a_sizes_read_value:
    assert property (
        (isRead && dbgReq.addr == OFF_PARAM_SIZES)
        |=> dbgRsp.ack && dbgRsp.rdata == 32'h2000_1088)
    else $error("Parameter sizes read value wrong");

    a_reserved_reads_zero:
    assert property (
        ((stateReg.evtSelect & ~EVT_SELECT_MASK) == 32'h0)
        && ((stateReg.evtBehaviour & ~EVT_BEHAV_MASK) == 32'h0)
        && ((stateReg.extSelect & ~EXT_SELECT_MASK) == 32'h0))
    else $error("Reserved control bits hold ones");

    a_identity_write_ignored:
    assert property (
        (isWrite && dbgReq.addr == OFF_CAP0) ##2 (isRead && dbgReq.addr == OFF_CAP0)
        |=> dbgRsp.rdata == CAP0_VALUE)
    else $error("Capability changed by a write");

    a_answer_pulse:
    assert property (
        dbgReq.valid |=> dbgRsp.ack ##1 (dbgRsp.ack == $past(dbgReq.valid)))
    else $error("Debug answer not one cycle after request");

    a_base_id_read:
    assert property (
        (isRead && dbgReq.addr == OFF_BASE_ID)
        |=> dbgRsp.rdata == {CODE_A, 8'h00, 4'hF, ARCH_MAJOR_VERSION,
                             ARCH_MINOR_VERSION, IMPL_REVISION})
    else $error("Base identity fields wrong");

endmodule // trace_event_regs

//--- testbench/debug_host_model.sv
// Debugger model that issues single-word accesses on the debug register port.
// Assumes the bench calls its access task and that the port is sampled on rising edges.
`timescale 1ns/1ps
module debug_host_model (
    // Clock
    input  wire logic                    core_clk,
    // Debug register port
    output trace_evt_pkg::dbg_req_t      dbgReq,
    input  wire trace_evt_pkg::dbg_rsp_t dbgRsp
);
    import trace_evt_pkg::*;

    // Port idle until the first access
    initial begin
        dbgReq = '0;
    end

    // One access: request held for one rising edge, answer sampled one edge later
    task automatic access(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
                          output logic [31:0] rdata, output logic ok);
        @(negedge core_clk);
        dbgReq.valid = 1'b1;
        dbgReq.write = wr;
        dbgReq.addr  = addr;
        dbgReq.wdata = wdata;
        @(negedge core_clk);
        // Released lines show the inverse so late sampling is caught
        dbgReq.valid = 1'b0;
        dbgReq.write = ~wr;
        dbgReq.addr  = ~addr;
        dbgReq.wdata = ~wdata;
        ok    = (dbgRsp.ack === 1'b1);
        rdata = dbgRsp.rdata;
    endtask
endmodule // debug_host_model

//--- testbench/trace_event_regs_test.sv
// Self-checking bench for the trace event select and identity registers.
// Assumes the debugger model drives the register port; bench drives the rest.
`timescale 1ns/1ps
module trace_event_regs_test;
    import trace_evt_pkg::*;

    // Identity values handed to the design, arbitrary
    localparam logic [7:0] TB_CODE = 8'hC3;
    localparam logic [3:0] TB_MAJ  = 4'h6;
    localparam logic [3:0] TB_MIN  = 4'h9;
    localparam logic [3:0] TB_REV  = 4'h5;

    // Expected constant register contents
    localparam logic [31:0] EXP_CAP0 = 32'h2000_0000
        | 32'h0800_0000
        | 32'h0000_0C00
        | 32'h0000_02A0
        | 32'h0000_0001;
    localparam logic [31:0] EXP_PSZ = 32'h2000_0000
        | 32'h0000_1088;
    localparam logic [31:0] EXP_BASE = {TB_CODE, 8'h00, 4'hF, TB_MAJ, TB_MIN, TB_REV};
    localparam logic [31:0] EXP_CAP3 = 32'h0D7B_0004;

    // Design signals
    logic          core_clk;
    logic          rst_n;
    dbg_req_t      dbgReq;
    dbg_rsp_t      dbgRsp;
    resource_bus_t resources;
    logic [46:0]   extInBus;
    logic          coreLowPower;
    logic [3:0]    eventElement;
    logic [3:0]    eventOut;
    logic [3:0]    extResource;
    logic          busTriggerEnable;
    logic          lowPowerBypass;
    logic [3:0]    enBits;
    int            num_errors;
    int            comparisons;
    logic [11:0]   idAddr [4];
    logic [31:0]   idExp  [4];
    int            extSel [4];

    trace_event_regs #(
        .CODE_A             (TB_CODE),
        .ARCH_MAJOR_VERSION (TB_MAJ),
        .ARCH_MINOR_VERSION (TB_MIN),
        .IMPL_REVISION      (TB_REV)
    ) DUT (
        .core_clk         (core_clk),
        .rst_n            (rst_n),
        .dbgReq           (dbgReq),
        .dbgRsp           (dbgRsp),
        .resources        (resources),
        .extInBus         (extInBus),
        .coreLowPower     (coreLowPower),
        .eventElement     (eventElement),
        .eventOut         (eventOut),
        .extResource      (extResource),
        .busTriggerEnable (busTriggerEnable),
        .lowPowerBypass   (lowPowerBypass)
    );

    debug_host_model host (
        .core_clk (core_clk),
        .dbgReq   (dbgReq),
        .dbgRsp   (dbgRsp)
    );

    // Core clock, 100 MHz
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Compare tasks, one per result width
    task automatic check32(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD time %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check4(input logic [3:0] got, input logic [3:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD time %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Register write; the answer must come one edge later
    task automatic wr(input logic [11:0] addr, input logic [31:0] data);
        logic [31:0] rd;
        logic        ok;
        host.access(1'b1, addr, data, rd, ok);
        check32({31'h0, ok}, 32'h1);
        check32(rd, 32'h0);
    endtask

    // Register read against an expected word
    task automatic rd_chk(input logic [11:0] addr, input logic [31:0] exp);
        logic [31:0] rd;
        logic        ok;
        host.access(1'b0, addr, 32'h0, rd, ok);
        check32({31'h0, ok}, 32'h1);
        check32(rd, exp);
    endtask

    // Drive resource levels, look at events one edge later
    task automatic ev_chk(input logic [15:0] single, input logic [7:0] pair,
                          input logic [3:0] exp);
        @(negedge core_clk);
        resources.single = single;
        resources.pair   = pair;
        @(negedge core_clk);
        check4(eventOut, exp);
        check4(eventElement, exp & enBits);
    endtask

    // Drive the external input bus, look at resources one edge later
    task automatic ext_chk(input logic [46:0] bus, input logic [3:0] exp);
        @(negedge core_clk);
        extInBus = bus;
        @(negedge core_clk);
        check4(extResource, exp);
    endtask

    // Counts, verdict and end of run
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        num_errors   = 0;
        comparisons  = 0;
        rst_n        = 1'b0;
        resources    = '0;
        extInBus     = '0;
        coreLowPower = 1'b0;
        enBits       = 4'h0;
        idAddr = '{OFF_CAP0, OFF_BASE_ID, OFF_PARAM_SIZES, OFF_CAP3};
        idExp  = '{EXP_CAP0, EXP_BASE, EXP_PSZ, EXP_CAP3};
        extSel = '{5, 23, 0, 46};
        repeat (3) @(negedge core_clk);
        rst_n = 1'b1;
        // Control registers start cleared
        rd_chk(OFF_EVT_SELECT, 32'h0);
        rd_chk(OFF_EVT_BEHAV, 32'h0);
        rd_chk(OFF_EXT_SELECT, 32'h0);
        // Identity registers are constant and ignore writes
        for (int k = 0; k < 4; k++) begin
            wr(idAddr[k], 32'hFFFF_FFFF);
            rd_chk(idAddr[k], idExp[k]);
        end
        wr(12'h100, 32'hFFFF_FFFF);
        rd_chk(12'h100, 32'h0);
        // Reserved bits drop on write
        wr(OFF_EVT_SELECT, 32'hFFFF_FFFF);
        rd_chk(OFF_EVT_SELECT, 32'h8F8F_8F8F);
        wr(OFF_EVT_BEHAV, 32'hFFFF_FFFF);
        rd_chk(OFF_EVT_BEHAV, 32'h0000_180F);
        check4({2'h0, lowPowerBypass, busTriggerEnable}, 4'h3);
        wr(OFF_EXT_SELECT, 32'hFFFF_FFFF);
        rd_chk(OFF_EXT_SELECT, 32'h3F3F_3F3F);
        wr(OFF_EVT_BEHAV, 32'h0000_0800);
        check4({2'h0, lowPowerBypass, busTriggerEnable}, 4'h1);
        // Every single resource, all four events at once
        for (int c = 0; c < 16; c++) begin
            wr(OFF_EVT_SELECT, {4{4'h0, 4'(c)}});
            ev_chk(16'(1 << c), 8'h00, 4'hF);
            ev_chk(~16'(1 << c), 8'hFF, 4'h0);
        end
        // Every pair; choice bit 3 set and ignored
        for (int c = 0; c < 8; c++) begin
            wr(OFF_EVT_SELECT, {4{4'h8, 1'b1, 3'(c)}});
            ev_chk(16'h0000, 8'(1 << c), 4'hF);
            ev_chk(16'hFFFF, ~8'(1 << c), 4'h0);
        end
        // Each event has its own field and kind bit
        wr(OFF_EVT_SELECT, 32'h0A07_0401);
        for (int k = 0; k < 4; k++) begin
            ev_chk(16'(1 << (3 * k + 1)), 8'h00, 4'(1 << k));
        end
        wr(OFF_EVT_SELECT, 32'h0080_0080);
        ev_chk(16'h0001, 8'h00, 4'hA);
        ev_chk(16'h0000, 8'h01, 4'h5);
        // Event element enables
        wr(OFF_EVT_SELECT, 32'h0000_0000);
        for (int e = 5; e < 16; e += 5) begin
            wr(OFF_EVT_BEHAV, 32'(e));
            enBits = 4'(e);
            ev_chk(16'h0001, 8'h00, 4'hF);
        end
        // External input selectors
        wr(OFF_EXT_SELECT, 32'h2E00_1705);
        for (int k = 0; k < 4; k++) begin
            ext_chk(47'(1) << extSel[k], 4'(1 << k));
        end
        wr(OFF_EXT_SELECT, 32'h3F2F_0001);
        ext_chk({47{1'b1}}, 4'h3);
        // Low power stops events unless bypassed
        coreLowPower = 1'b1;
        ev_chk(16'hFFFF, 8'hFF, 4'h0);
        check4(extResource, 4'h0);
        wr(OFF_EVT_BEHAV, 32'h0000_100F);
        ev_chk(16'hFFFF, 8'hFF, 4'hF);
        check4(extResource, 4'h3);
        close_out();
    end
endmodule // trace_event_regs_test
